// ==== inc/crt_dac_pkg.sv ====
// constants and types shared by the crt dac port and hot plug control logic
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package crt_dac_pkg;

    //--------------------------------------------------------------------------
    // register map
    //--------------------------------------------------------------------------
    localparam int ADDR_W = 20;
    localparam logic [19:0] CTL_OFFSET = 20'hE1100;
    localparam logic [31:0] CTL_RESET = 32'h0004_0000;
    localparam logic [31:0] CTL_WRITABLE = 32'hE0FF_0018;

    localparam int PORT_EN_BIT = 31;
    localparam int SRC_LSB = 29;
    localparam int STATUS_LSB = 24;
    localparam int HPD_EN_BIT = 23;
    localparam int ACT_BIT = 22;
    localparam int WARM_BIT = 21;
    localparam int SAMP_BIT = 20;
    localparam int THR_LSB = 18;
    localparam int REF_BIT = 17;
    localparam int FORCE_BIT = 16;
    localparam int VPOL_BIT = 4;
    localparam int HPOL_BIT = 3;

    localparam logic [1:0] SRC_A = 2'h0;
    localparam logic [1:0] SRC_B = 2'h1;
    localparam logic [1:0] SRC_C = 2'h2;

    //--------------------------------------------------------------------------
    // timing, counted on the raw reference clock
    //--------------------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int ACT_SHORT_CYCLES = 64;
    localparam int ACT_LONG_CYCLES = 128;
    localparam int WARMUP_SHORT_MS = 4;
    localparam int WARMUP_LONG_MS = 8;
    localparam int WARMUP_SHORT_CYCLES = WARMUP_SHORT_MS * (CLK_HZ / 1000);
    localparam int WARMUP_LONG_CYCLES = WARMUP_LONG_MS * (CLK_HZ / 1000);
    localparam int SAMPLE_SHORT_S = 2;
    localparam int SAMPLE_LONG_S = 4;
    localparam int SAMPLE_SHORT_CYCLES = SAMPLE_SHORT_S * CLK_HZ;
    localparam int SAMPLE_LONG_CYCLES = SAMPLE_LONG_S * CLK_HZ;
    localparam int TIMER_W = 32;

    // sync pins idle high out of reset, since both polarity bits reset to zero
    localparam logic SYNC_RESET_LEVEL = 1'h1;

    //--------------------------------------------------------------------------
    // types
    //--------------------------------------------------------------------------
    typedef struct packed {
        logic enabled;
        logic vblank;
        logic vsync;
        logic hsync;
    } trans_video_type;

    typedef struct packed {
        logic warm;
        logic sense;
        logic vref_high;
        logic [1:0] threshold;
    } hpd_analog_type;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_WARMUP,
        ST_ACTIVE
    } hpd_state_type;

endpackage : crt_dac_pkg

// ==== src/crt_dac_port_hotplug_control.sv ====
// crt dac port control register, source routing, syncs and hot plug engine
module crt_dac_port_hotplug_control
    import crt_dac_pkg::*;
#(
    parameter int WARMUP_SHORT = WARMUP_SHORT_CYCLES,
    parameter int WARMUP_LONG = WARMUP_LONG_CYCLES,
    parameter int SAMPLE_SHORT = SAMPLE_SHORT_CYCLES,
    parameter int SAMPLE_LONG = SAMPLE_LONG_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // register access
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    // fuse
    input wire logic dac_disable_fuse,
    // transcoders, index 0 is A
    input wire trans_video_type [2:0] trans_video,
    // dac port
    output logic dac_enable,
    output trans_video_type dac_video,
    output logic hsync_out,
    output logic vsync_out,
    // hot plug analog circuit
    output hpd_analog_type hpd_analog,
    input wire logic blue_sense,
    input wire logic green_sense,
    // to south interrupt status
    output logic hotplug_event
);

    //--------------------------------------------------------------------------
    // elaboration checks
    //--------------------------------------------------------------------------
    if (WARMUP_SHORT < 1 || WARMUP_LONG < 1 || SAMPLE_SHORT < 1 || SAMPLE_LONG < 1)
    begin : g_count_check
        $error("crt_dac_port_hotplug_control: period counts must be at least 1");
    end

    //--------------------------------------------------------------------------
    // declarations
    //--------------------------------------------------------------------------
    logic port_en_r;
    logic [1:0] src_sel_r;
    logic [1:0] status_r;
    logic [1:0] status_prev_r;
    logic hpd_en_r;
    logic act_long_r;
    logic warm_long_r;
    logic samp_long_r;
    logic [1:0] thr_r;
    logic ref_r;
    logic force_r;
    logic vpol_r;
    logic hpol_r;
    logic [31:0] reg_rdata_r;
    logic dac_enable_r;
    trans_video_type dac_video_r;
    hpd_analog_type hpd_analog_r;
    logic hotplug_event_r;
    logic vblank_prev_r;
    logic [1:0] last_result_r;
    logic forced_r;
    hpd_state_type state_r;
    hpd_state_type state_nxt;

    logic ctl_sel;
    logic ctl_wr;
    logic port_on;
    logic tmr_load;
    logic [TIMER_W-1:0] tmr_value;
    logic tmr_done;
    logic sample_now;
    logic frame_start;
    logic [1:0] result;
    logic report;
    logic force_done;

    //--------------------------------------------------------------------------
    // helpers
    //--------------------------------------------------------------------------
    function automatic trans_video_type pick_source(input logic [1:0] sel,
                                                    input trans_video_type [2:0] tv);
        trans_video_type v;
        v = '0;
        unique case (sel)
            SRC_A: v = tv[0];
            SRC_B: v = tv[1];
            SRC_C: v = tv[2];
            default: v = '0;
        endcase
        return v;
    endfunction : pick_source

    function automatic logic [31:0] ctl_image();
        logic [31:0] img;
        img = '0;
        img[PORT_EN_BIT] = port_en_r;
        img[SRC_LSB +: 2] = src_sel_r;
        img[STATUS_LSB +: 2] = status_r;
        img[HPD_EN_BIT] = hpd_en_r;
        img[ACT_BIT] = act_long_r;
        img[WARM_BIT] = warm_long_r;
        img[SAMP_BIT] = samp_long_r;
        img[THR_LSB +: 2] = thr_r;
        img[REF_BIT] = ref_r;
        img[FORCE_BIT] = force_r;
        img[VPOL_BIT] = vpol_r;
        img[HPOL_BIT] = hpol_r;
        return img & CTL_WRITABLE | {6'h00, status_r, 24'h00_0000} & 32'h0300_0000;
    endfunction : ctl_image

    //--------------------------------------------------------------------------
    // register access
    //--------------------------------------------------------------------------
    assign ctl_sel = (reg_addr == CTL_OFFSET);
    assign ctl_wr = reg_wr && ctl_sel;

    // plain read/write fields; reserved bits are never stored
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            port_en_r <= CTL_RESET[PORT_EN_BIT];
            src_sel_r <= CTL_RESET[SRC_LSB +: 2];
            hpd_en_r <= CTL_RESET[HPD_EN_BIT];
            act_long_r <= CTL_RESET[ACT_BIT];
            warm_long_r <= CTL_RESET[WARM_BIT];
            samp_long_r <= CTL_RESET[SAMP_BIT];
            thr_r <= CTL_RESET[THR_LSB +: 2];
            ref_r <= CTL_RESET[REF_BIT];
            vpol_r <= CTL_RESET[VPOL_BIT];
            hpol_r <= CTL_RESET[HPOL_BIT];
        end else if (ctl_wr) begin
            port_en_r <= reg_wdata[PORT_EN_BIT];
            src_sel_r <= reg_wdata[SRC_LSB +: 2];
            hpd_en_r <= reg_wdata[HPD_EN_BIT];
            act_long_r <= reg_wdata[ACT_BIT];
            warm_long_r <= reg_wdata[WARM_BIT];
            samp_long_r <= reg_wdata[SAMP_BIT];
            thr_r <= reg_wdata[THR_LSB +: 2];
            ref_r <= reg_wdata[REF_BIT];
            vpol_r <= reg_wdata[VPOL_BIT];
            hpol_r <= reg_wdata[HPOL_BIT];
        end
    end

    // unmapped reads return zero so software sees no stale data
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            reg_rdata_r <= '0;
        end else if (reg_rd && ctl_sel) begin
            reg_rdata_r <= ctl_image();
        end else begin
            reg_rdata_r <= '0;
        end
    end

    //--------------------------------------------------------------------------
    // port enable and source routing
    //--------------------------------------------------------------------------
    assign port_on = dac_enable_r;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            dac_enable_r <= 1'b0;
        end else begin
            dac_enable_r <= port_en_r && !dac_disable_fuse;
        end
    end

    // the selected feed also drives the detection spacing, so route it always
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            dac_video_r <= '0;
        end else begin
            dac_video_r <= pick_source(src_sel_r, trans_video);
        end
    end

    sync_driver u_vsync (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .port_on(port_on),
        .active_high(vpol_r),
        .sync_in(dac_video_r.vsync),
        .sync_out(vsync_out)
    );

    sync_driver u_hsync (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .port_on(port_on),
        .active_high(hpol_r),
        .sync_in(dac_video_r.hsync),
        .sync_out(hsync_out)
    );

    //--------------------------------------------------------------------------
    // detection sequencer
    //--------------------------------------------------------------------------
    assign frame_start = dac_video_r.vblank && !vblank_prev_r;
    assign sample_now = (state_r == ST_ACTIVE) && tmr_done;
    assign result = {green_sense, blue_sense};
    assign report = sample_now && (forced_r || result != last_result_r);
    assign force_done = sample_now && forced_r;

    always_comb begin
        state_nxt = state_r;
        tmr_load = 1'b0;
        tmr_value = '0;
        unique case (state_r)
            ST_IDLE, ST_WAIT: begin
                if (force_r || (hpd_en_r && state_r == ST_IDLE)) begin
                    state_nxt = ST_WARMUP;
                    tmr_load = 1'b1;
                    tmr_value = warm_long_r ? TIMER_W'(WARMUP_LONG)
                                            : TIMER_W'(WARMUP_SHORT);
                end else if (!hpd_en_r) begin
                    state_nxt = ST_IDLE;
                end else if (dac_video_r.enabled ? frame_start : tmr_done) begin
                    state_nxt = ST_WARMUP;
                    tmr_load = 1'b1;
                    tmr_value = warm_long_r ? TIMER_W'(WARMUP_LONG)
                                            : TIMER_W'(WARMUP_SHORT);
                end
            end
            ST_WARMUP: begin
                if (!hpd_en_r && !forced_r) begin
                    state_nxt = ST_IDLE;
                end else if (tmr_done) begin
                    state_nxt = ST_ACTIVE;
                    tmr_load = 1'b1;
                    tmr_value = act_long_r ? TIMER_W'(ACT_LONG_CYCLES)
                                           : TIMER_W'(ACT_SHORT_CYCLES);
                end
            end
            ST_ACTIVE: begin
                if (!hpd_en_r && !forced_r) begin
                    state_nxt = ST_IDLE;
                end else if (tmr_done) begin
                    state_nxt = hpd_en_r ? ST_WAIT : ST_IDLE;
                    tmr_load = hpd_en_r;
                    tmr_value = samp_long_r ? TIMER_W'(SAMPLE_LONG)
                                            : TIMER_W'(SAMPLE_SHORT);
                end
            end
        endcase
    end

    hpd_timer #(
        .WIDTH(TIMER_W)
    ) u_timer (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .load(tmr_load),
        .load_value(tmr_value),
        .done(tmr_done)
    );

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state_r <= ST_IDLE;
            vblank_prev_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            vblank_prev_r <= dac_video_r.vblank;
        end
    end

    // a cycle counts as forced if a pending force launched it
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            forced_r <= 1'b0;
        end else if (state_nxt == ST_WARMUP && state_r != ST_WARMUP) begin
            forced_r <= force_r;
        end else if (state_nxt == ST_IDLE || state_nxt == ST_WAIT) begin
            forced_r <= 1'b0;
        end
    end

    // a fresh write of one in the completing cycle wins and runs again
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            force_r <= CTL_RESET[FORCE_BIT];
        end else if (ctl_wr && reg_wdata[FORCE_BIT]) begin
            force_r <= 1'b1;
        end else if (force_done) begin
            force_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            last_result_r <= '0;
        end else if (sample_now) begin
            last_result_r <= result;
        end
    end

    //--------------------------------------------------------------------------
    // channel status and event
    //--------------------------------------------------------------------------
    // a detection in the same cycle as a clearing write takes priority
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            status_r <= CTL_RESET[STATUS_LSB +: 2];
        end else if (report) begin
            status_r <= result;
        end else if (ctl_wr) begin
            status_r <= status_r & ~reg_wdata[STATUS_LSB +: 2];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            status_prev_r <= CTL_RESET[STATUS_LSB +: 2];
            hotplug_event_r <= 1'b0;
        end else begin
            status_prev_r <= status_r;
            hotplug_event_r <= |(status_r ^ status_prev_r);
        end
    end

    //--------------------------------------------------------------------------
    // analog circuit control
    //--------------------------------------------------------------------------
    // settings pass through unchanged; legal pairings are software's duty
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            hpd_analog_r <= '0;
        end else begin
            hpd_analog_r.warm <= (state_nxt == ST_WARMUP) || (state_nxt == ST_ACTIVE);
            hpd_analog_r.sense <= (state_nxt == ST_ACTIVE);
            hpd_analog_r.vref_high <= ref_r;
            hpd_analog_r.threshold <= thr_r;
        end
    end

    //--------------------------------------------------------------------------
    // outputs
    //--------------------------------------------------------------------------
    assign reg_rdata = reg_rdata_r;
    assign dac_enable = dac_enable_r;
    assign dac_video = dac_video_r;
    assign hpd_analog = hpd_analog_r;
    assign hotplug_event = hotplug_event_r;

endmodule : crt_dac_port_hotplug_control

// ==== src/hpd_timer.sv ====
// down counter giving a one-cycle done pulse a loaded number of cycles later
module hpd_timer
    import crt_dac_pkg::*;
#(
    parameter int WIDTH = TIMER_W
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // control
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    // result
    output logic done
);

    if (WIDTH < 2) begin : g_width_check
        $error("hpd_timer: WIDTH must be at least 2");
    end

    logic [WIDTH-1:0] cnt_r;
    logic busy_r;
    logic done_r;

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cnt_r <= '0;
            busy_r <= 1'b0;
        end else if (load) begin
            cnt_r <= load_value;
            busy_r <= 1'b1;
        end else if (busy_r) begin
            cnt_r <= cnt_r - WIDTH'(1);
            busy_r <= (cnt_r > WIDTH'(1));
        end
    end

    // a reload in the expiring cycle suppresses the stale pulse
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            done_r <= 1'b0;
        end else begin
            done_r <= busy_r && !load && (cnt_r == WIDTH'(1));
        end
    end

    assign done = done_r;

endmodule : hpd_timer

// ==== src/sync_driver.sv ====
// one sync output with programmable polarity and a defined level while off
module sync_driver
    import crt_dac_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // control
    input wire logic port_on,
    input wire logic active_high,
    // sync
    input wire logic sync_in,
    output logic sync_out
);

    logic out_r;

    // internal sync is active high; an idle port parks on the inactive level
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            out_r <= SYNC_RESET_LEVEL;
        end else if (!port_on) begin
            out_r <= ~active_high;
        end else begin
            out_r <= active_high ? sync_in : ~sync_in;
        end
    end

    assign sync_out = out_r;

endmodule : sync_driver

// ==== tb/crt_dac_port_hotplug_control_monitor.sv ====
// concurrent checks on the ports of the crt dac port and hot plug block
module crt_dac_port_hotplug_control_monitor
    import crt_dac_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // register access
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_rdata,
    // port
    input wire logic dac_disable_fuse,
    input wire logic dac_enable,
    input wire trans_video_type dac_video,
    input wire logic hsync_out,
    // hot plug
    input wire hpd_analog_type hpd_analog,
    input wire logic hotplug_event
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);
    //--------------------------------------------------------------------------
    // activation length counter
    //--------------------------------------------------------------------------
    logic [7:0] sense_cnt_r;
    always_ff @(posedge ref_clk) begin
        if (!nrst || !hpd_analog.sense) begin
            sense_cnt_r <= 8'h0;
        end else if (sense_cnt_r != 8'hFF) begin
            sense_cnt_r <= sense_cnt_r + 8'h1;
        end
    end
    //--------------------------------------------------------------------------
    // assertions
    //--------------------------------------------------------------------------
    a_enable_has_cause: assert property ($changed(dac_enable) |->
        $past(reg_wr, 2) || ($past(dac_disable_fuse) != $past(dac_disable_fuse, 2)))
        else $error("port enable moved without a write or fuse change");
    a_fuse_blocks_port: assert property (dac_disable_fuse [*2] |-> !dac_enable)
        else $error("port enabled while the fuse is blown");
    a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data not zero outside a read");
    a_reserved_read_zero: assert property (reg_rd |=>
        (reg_rdata & 32'h1C00_FFE7) == 32'h0)
        else $error("reserved bits read nonzero");
    a_unmapped_read_zero: assert property (reg_rd && reg_addr != CTL_OFFSET |=>
        reg_rdata == 32'h0)
        else $error("unmapped read returned data");
    a_sync_follows_video: assert property ((dac_enable && !reg_wr) [*2] ##1
        (dac_enable && $changed(dac_video.hsync)) |=> $changed(hsync_out))
        else $error("enabled hsync did not follow the source");
    a_sync_idle_steady: assert property ((!dac_enable && !reg_wr) [*3] |->
        $stable(hsync_out))
        else $error("disabled hsync moved");
    a_event_one_pulse: assert property (hotplug_event |=> !hotplug_event)
        else $error("hot plug event longer than one cycle");
    a_warmup_no_sense: assert property ($rose(hpd_analog.warm) |=>
        !hpd_analog.sense [*8])
        else $error("sensing began without warmup");
    a_activation_length: assert property ($fell(hpd_analog.sense) |->
        sense_cnt_r inside {[8'h3E:8'h44], [8'h7E:8'h84]})
        else $error("activation not 64 or 128 cycles");
endmodule : crt_dac_port_hotplug_control_monitor

// ==== tb/crt_dac_port_hotplug_control_tb_top.sv ====
// self-checking bench for the crt dac port and hot plug control block
module crt_dac_port_hotplug_control_tb_top
    import crt_dac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // short periods keep the run small; expectations derive from these
    localparam int WS = 20;
    localparam int WL = 40;
    localparam int SS = 200;
    localparam int SL = 400;
    logic ref_clk = 1'h0;
    logic nrst = 1'h0;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [ADDR_W-1:0] reg_addr = CTL_OFFSET;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic dac_disable_fuse = 1'h0;
    trans_video_type [2:0] trans_video = 12'h0;
    trans_video_type dac_video;
    hpd_analog_type hpd_analog;
    logic dac_enable, hsync_out, vsync_out, blue_sense, green_sense, hotplug_event;
    logic [1:0] attached = 2'h0;
    int n_fail = 0;
    int n_compared = 0;
    int n_events = 0;

    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (hotplug_event === 1'h1) n_events <= n_events + 1;

    crt_dac_port_hotplug_control #(.WARMUP_SHORT(WS), .WARMUP_LONG(WL),
        .SAMPLE_SHORT(SS), .SAMPLE_LONG(SL)) dut (
        .ref_clk(ref_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .dac_disable_fuse(dac_disable_fuse), .trans_video(trans_video),
        .dac_enable(dac_enable), .dac_video(dac_video), .hsync_out(hsync_out),
        .vsync_out(vsync_out), .hpd_analog(hpd_analog), .blue_sense(blue_sense),
        .green_sense(green_sense), .hotplug_event(hotplug_event));

    crt_monitor_model crt (.ref_clk(ref_clk), .attached(attached),
        .hpd_analog(hpd_analog), .blue_sense(blue_sense), .green_sense(green_sense));
    //--------------------------------------------------------------------------
    // tasks and expectations
    //--------------------------------------------------------------------------
    task automatic end_of_test();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'h0;
    endtask : wr

    task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'h0;
        @(negedge ref_clk);
        d = reg_rdata;
    endtask : rd_reg

    // reads until the masked image matches; a hang is cut short here
    task automatic poll(input logic [31:0] m, input logic [31:0] v, output logic [31:0] d);
        for (int i = 0; i < 300; i++) begin
            rd_reg(CTL_OFFSET, d);
            if ((d & m) === v) return;
        end
        n_fail++;
        $display("[FAIL] %0t wait for register image ran out", $time);
        end_of_test();
    endtask : poll

    function automatic trans_video_type exp_video(input logic [1:0] s,
                                                  input trans_video_type [2:0] tv);
        return (s == 2'h3) ? 4'h0 : tv[s];
    endfunction : exp_video

    function automatic logic exp_sync(input logic en, input logic pol, input logic s);
        return en ? (pol ? s : ~s) : ~pol;
    endfunction : exp_sync
    //--------------------------------------------------------------------------
    // main sequence
    //--------------------------------------------------------------------------
    initial begin
        logic [31:0] rd;
        logic [1:0] s, pol, thr;
        logic en, fz, rf;
        trans_video_type v;
        int k, ev;
        time t0;
        void'($urandom(34584));
        repeat (12) @(posedge ref_clk);
        nrst <= 1'h1;
        rd_reg(CTL_OFFSET, rd);
        check(rd, CTL_RESET, "reset image");
        wr(CTL_OFFSET, 32'hFFF6_FFFF);
        rd_reg(CTL_OFFSET, rd);
        check(rd, 32'hFFF6_FFFF & CTL_WRITABLE, "writable image");
        wr(CTL_OFFSET + 20'h4, 32'h0);
        rd_reg(CTL_OFFSET + 20'h4, rd);
        check(rd, 32'h0, "unmapped read");
        rd_reg(CTL_OFFSET, rd);
        check(rd, 32'hFFF6_FFFF & CTL_WRITABLE, "unmapped write kept out");
        $display("test registers done");
        for (int i = 0; i < 12; i++) begin
            s = i[1:0];
            en = (i < 2) | 1'($urandom);
            fz = (i == 0) | ($urandom_range(3) == 0);
            pol = 2'($urandom);
            @(posedge ref_clk);
            trans_video <= 12'($urandom);
            dac_disable_fuse <= fz;
            wr(CTL_OFFSET, {en, s, 24'h0, pol, 3'h0});
            repeat (3) @(posedge ref_clk);
            @(negedge ref_clk);
            v = exp_video(s, trans_video);
            check(dac_enable, en & ~fz, "port enable");
            check(dac_video, v, "routed video");
            check(hsync_out, exp_sync(en & ~fz, pol[0], v.hsync), "hsync");
            check(vsync_out, exp_sync(en & ~fz, pol[1], v.vsync), "vsync");
        end
        $display("test port and syncs done");
        @(posedge ref_clk) trans_video <= 12'h0;
        for (int i = 0; i < 4; i++) begin
            attached <= i[1:0];
            thr = (i < 2) ? i[1:0] : 2'(i - 1);
            rf = (i == 2);
            ev = n_events;
            wr(CTL_OFFSET, {8'h0, 1'h0, i[0], i[1], 1'h0, thr, rf, 1'h1, 16'h0});
            for (k = 0; k < 100 && hpd_analog.sense !== 1'h1; k++) @(negedge ref_clk);
            check(k >= (i[1] ? WL : WS) && k <= (i[1] ? WL : WS) + 6, 1'h1, "warmup");
            if (k == 100) end_of_test();
            check(hpd_analog.threshold, thr, "threshold");
            check(hpd_analog.vref_high, rf, "reference");
            poll(32'h0001_0000, 32'h0, rd);
            check(rd[25:24], i[1:0], "forced result");
            wr(CTL_OFFSET, 32'h0300_0000);
            rd_reg(CTL_OFFSET, rd);
            check(rd[25:24], 2'h0, "status cleared");
            repeat (3) @(posedge ref_clk);
            check(n_events - ev, (i != 0) ? 2 : 0, "event count");
        end
        $display("test forced detection done");
        attached <= 2'h2;
        wr(CTL_OFFSET, 32'h0084_0000);
        poll(32'h0300_0000, 32'h0200_0000, rd);
        check(rd[25:24], 2'h2, "periodic report");
        t0 = $time;
        attached <= 2'h1;
        poll(32'h0300_0000, 32'h0100_0000, rd);
        k = int'(($time - t0) / 20);
        check(k >= SS && k < SL, 1'h1, "sample spacing");
        wr(CTL_OFFSET, 32'h0300_0000);
        attached <= 2'h3;
        repeat (600) @(posedge ref_clk);
        rd_reg(CTL_OFFSET, rd);
        check(rd[25:24], 2'h0, "no detection while off");
        $display("test periodic detection done");
        end_of_test();
    end
endmodule : crt_dac_port_hotplug_control_tb_top

bind crt_dac_port_hotplug_control crt_dac_port_hotplug_control_monitor u_monitor (
    .ref_clk(ref_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_rdata(reg_rdata), .dac_disable_fuse(dac_disable_fuse),
    .dac_enable(dac_enable), .dac_video(dac_video), .hsync_out(hsync_out),
    .hpd_analog(hpd_analog), .hotplug_event(hotplug_event));

// ==== tb/crt_monitor_model.sv ====
// stand-in for the crt monitor: comparator answers only while sensing
module crt_monitor_model
    import crt_dac_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // channels the bench has attached, {green, blue}
    input wire logic [1:0] attached,
    // hot plug circuit
    input wire hpd_analog_type hpd_analog,
    output logic blue_sense,
    output logic green_sense
);
    timeunit 1ns;
    timeprecision 1ps;
    logic junk_r = 1'h0;
    // an idle comparator wanders, so a stale level can never pass as a result
    always @(posedge ref_clk) junk_r <= ~junk_r;
    assign blue_sense = hpd_analog.sense ? attached[0] : junk_r;
    assign green_sense = hpd_analog.sense ? attached[1] : ~junk_r;
endmodule : crt_monitor_model
